// ==== pss_regs.svh ====
// constants for the status and memory supervisor
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_HZ        50000000
`define PSS_LAMP_MS       500
`define PSS_DM_BASE_WORDS 16'h03E8
`define PSS_DM_EXT_WORDS  16'h0FA0
`define PSS_BAUD_DEFAULT  32'h0000_9600
`define PSS_FMT_8N1       8'h00
`define PSS_YEAR_INIT     16'h07D0
`define PSS_MONTH_INIT    8'h01
`define PSS_DAY_INIT      8'h01
`define PSS_TIME_ZERO     8'h00
`define PSS_HANDLER_INTR  8'h64
`define PSS_ERR_NONE      3'h0
`define PSS_ERR_DIV0      3'h1
`define PSS_ERR_STEP0     3'h2
`define PSS_ERR_STACK     3'h3
`define PSS_ERR_OPCODE    3'h4
`define PSS_ERR_INDEX     3'h5
`endif

// ==== pss_pkg.sv ====
// types for the status and memory supervisor
package pss_pkg;
  typedef enum logic [1:0] {
    PSS_LAMP  = 2'b00,
    PSS_RTCLD = 2'b01,
    PSS_RUN   = 2'b10
  } pss_state_t;
endpackage

// ==== pss_supervisor.sv ====
// status indicator, memory window and clock start-up supervisor
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_supervisor #(
  parameter int unsigned LAMP_CYC = (`PSS_CLK_HZ / 1000) * `PSS_LAMP_MS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // switches and module presence pins
  input  wire logic        retention_switch,
  input  wire logic        auth_bypass_switch,
  input  wire logic        program_halt_switch,
  input  wire logic        module_present,
  input  wire logic        resync_disable,
  // battery-backed time from the option module
  input  wire logic [15:0] mod_year,
  input  wire logic [7:0]  mod_month,
  input  wire logic [7:0]  mod_day,
  input  wire logic [7:0]  mod_hour,
  input  wire logic [7:0]  mod_min,
  input  wire logic [7:0]  mod_sec,
  input  wire logic        mod_time_valid,
  // running clock seconds and minutes, clock loss
  input  wire logic [7:0]  cur_min,
  input  wire logic [7:0]  cur_sec,
  input  wire logic        clock_lost,
  input  wire logic        host_set_time,
  // data memory access from the interpreter
  input  wire logic        dm_req,
  input  wire logic        dm_we,
  input  wire logic [15:0] dm_index,
  output logic             dm_en,
  output logic             dm_we_ok,
  output logic             dm_read_zero,
  // system variable index check
  input  wire logic        sysvar_req,
  input  wire logic [15:0] sysvar_index,
  input  wire logic [15:0] sysvar_size,
  // interpreter events
  input  wire logic        prog_corrupt,
  input  wire logic        pause_stmt,
  input  wire logic        host_halt,
  input  wire logic        host_resume,
  input  wire logic        err_valid,
  input  wire logic [2:0]  err_kind,
  input  wire logic [7:0]  err_func,
  input  wire logic        handler_reg,
  input  wire logic [7:0]  handler_intr,
  input  wire logic        display_fitted,
  // controls out
  output logic             clear_volatile,
  output logic             clear_retentive,
  output logic             auth_bypass,
  output logic             program_run,
  output logic [31:0]      baud_rate,
  output logic [7:0]       serial_fmt,
  output logic             rtc_load,
  output logic [15:0]      rtc_year,
  output logic [7:0]       rtc_month,
  output logic [7:0]       rtc_day,
  output logic [7:0]       rtc_hour,
  output logic [7:0]       rtc_min,
  output logic [7:0]       rtc_sec,
  output logic             clock_lost_flag,
  output logic             handler_call,
  output logic [2:0]       err_cause,
  output logic [7:0]       err_function,
  output logic             disp_show,
  output logic [2:0]       disp_cause,
  output logic [7:0]       disp_function,
  // indicators
  output logic             led_clock_err,
  output logic             led_pause,
  output logic             led_run_err
);

  // pin synchronisers, two flip-flops each
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff <= 5'h0_0;
      sync2_ff <= 5'h0_0;
    end
    else
    begin
      sync1_ff <= {retention_switch, auth_bypass_switch, program_halt_switch,
                   module_present, resync_disable};
      sync2_ff <= sync1_ff;
    end
  end
  wire s_ret   = sync2_ff[4];
  wire s_auth  = sync2_ff[3];
  wire s_halt  = sync2_ff[2];
  wire s_mod   = sync2_ff[1];
  wire s_nores = sync2_ff[0];

  pss_pkg::pss_state_t state_ff, nxt_state;
  logic [31:0] lamp_cnt_ff;
  logic        mod_ff;
  logic        halt_boot_ff;
  logic        pause_ff;
  logic        run_err_ff;

  wire lamp_done = (lamp_cnt_ff >= LAMP_CYC - 1);
  wire in_lamp   = (state_ff == pss_pkg::PSS_LAMP);

  // start-up sequence: lamp test, clock load every boot, run
  always_comb
  begin
    case (state_ff)
      pss_pkg::PSS_LAMP:  nxt_state = lamp_done ? pss_pkg::PSS_RTCLD : pss_pkg::PSS_LAMP;
      pss_pkg::PSS_RTCLD: nxt_state = pss_pkg::PSS_RUN;
      pss_pkg::PSS_RUN:   nxt_state = pss_pkg::PSS_RUN;
      default:            nxt_state = pss_pkg::PSS_LAMP;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff    <= pss_pkg::PSS_LAMP;
      lamp_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      state_ff    <= nxt_state;
      lamp_cnt_ff <= in_lamp ? lamp_cnt_ff + 32'h0000_0001 : lamp_cnt_ff;
    end
  end

  // straps caught at the end of the lamp test, after the synchronisers settle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mod_ff       <= 1'b0;
      halt_boot_ff <= 1'b0;
    end
    else if (in_lamp && lamp_done)
    begin
      mod_ff       <= s_mod;
      halt_boot_ff <= s_halt;
    end
  end

  // data window: 1000 words base, 4000 with the module
  wire [15:0] dm_limit = mod_ff ? `PSS_DM_EXT_WORDS : `PSS_DM_BASE_WORDS;
  wire        dm_ok    = (dm_index != 16'h0000) && (dm_index <= dm_limit);
  assign dm_en        = dm_req && dm_ok;
  assign dm_we_ok     = dm_req && dm_we && dm_ok;
  assign dm_read_zero = dm_req && !dm_we && !dm_ok;

  // clearing at power-up; the volatile pass waits for the module answer
  wire keep_vol = mod_ff && s_ret;
  assign clear_volatile  = (state_ff == pss_pkg::PSS_RTCLD) && !keep_vol;
  assign clear_retentive = (state_ff == pss_pkg::PSS_RTCLD) && !s_ret;

  // switch-driven controls
  assign auth_bypass = s_auth;
  assign program_run = (state_ff == pss_pkg::PSS_RUN) && !s_halt && !pause_ff
                       && !prog_corrupt;
  // a zero baud means keep the stored setting; only the halt boot forces the default
  assign baud_rate   = halt_boot_ff ? `PSS_BAUD_DEFAULT : 32'h0000_0000;
  assign serial_fmt  = `PSS_FMT_8N1;

  // clock load: default date, module time at start, hourly resync
  wire hour_mark = (cur_min == `PSS_TIME_ZERO) && (cur_sec == `PSS_TIME_ZERO);
  logic mark_ff;
  wire use_mod   = mod_ff && mod_time_valid;
  wire boot_load = (state_ff == pss_pkg::PSS_RTCLD);
  wire resync    = (state_ff == pss_pkg::PSS_RUN) && use_mod && !s_nores
                   && hour_mark && !mark_ff;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rtc_load  <= 1'b0;
      rtc_year  <= `PSS_YEAR_INIT;
      rtc_month <= `PSS_MONTH_INIT;
      rtc_day   <= `PSS_DAY_INIT;
      rtc_hour  <= `PSS_TIME_ZERO;
      rtc_min   <= `PSS_TIME_ZERO;
      rtc_sec   <= `PSS_TIME_ZERO;
      mark_ff   <= 1'b0;
    end
    else
    begin
      mark_ff  <= hour_mark;
      rtc_load <= boot_load || resync;
      if ((boot_load && use_mod) || resync)
      begin
        rtc_year  <= mod_year;
        rtc_month <= mod_month;
        rtc_day   <= mod_day;
        rtc_hour  <= mod_hour;
        rtc_min   <= mod_min;
        rtc_sec   <= mod_sec;
      end
      else if (boot_load)
      begin
        rtc_year  <= `PSS_YEAR_INIT;
        rtc_month <= `PSS_MONTH_INIT;
        rtc_day   <= `PSS_DAY_INIT;
        rtc_hour  <= `PSS_TIME_ZERO;
        rtc_min   <= `PSS_TIME_ZERO;
        rtc_sec   <= `PSS_TIME_ZERO;
      end
    end
  end

  // clock lost: set wins over the host's time set
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      clock_lost_flag <= 1'b0;
    else if (clock_lost)
      clock_lost_flag <= 1'b1;
    else if (host_set_time)
      clock_lost_flag <= 1'b0;
  end

  // error qualification: only the five kinds count
  wire idx_bad   = sysvar_req && ((sysvar_index == 16'h0000) || sysvar_index[15]
                   || (sysvar_index > sysvar_size));
  wire kind_ok   = (err_kind >= `PSS_ERR_DIV0) && (err_kind <= `PSS_ERR_INDEX);
  wire err_hit   = (err_valid && kind_ok) || idx_bad;
  wire [2:0] err_k = idx_bad ? `PSS_ERR_INDEX : err_kind;
  wire handled   = handler_reg && (handler_intr == `PSS_HANDLER_INTR);

  // pause and run-error latches; a new cause beats a resume in the same cycle
  wire  pause_set = pause_stmt || host_halt || (err_hit && !handled);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pause_ff     <= 1'b0;
      run_err_ff   <= 1'b0;
      err_cause    <= `PSS_ERR_NONE;
      err_function <= 8'h00;
      handler_call <= 1'b0;
      disp_show    <= 1'b0;
      disp_cause   <= `PSS_ERR_NONE;
      disp_function <= 8'h00;
    end
    else
    begin
      handler_call <= err_hit && handled;
      if (pause_set)
        pause_ff <= 1'b1;
      else if (host_resume)
        pause_ff <= 1'b0;
      if (err_hit && !handled)
        run_err_ff <= 1'b1;
      else if (host_resume)
        run_err_ff <= 1'b0;
      if (err_hit)
      begin
        err_cause     <= err_k;
        err_function  <= err_func;
        disp_show     <= display_fitted;
        disp_cause    <= err_k;
        disp_function <= err_func;
      end
    end
  end

  // indicators: lamp test first, then own conditions; corrupt and switch hold pause
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      led_clock_err <= 1'b1;
      led_pause     <= 1'b1;
      led_run_err   <= 1'b1;
    end
    else
    begin
      led_clock_err <= in_lamp || clock_lost_flag;
      led_pause     <= in_lamp || pause_ff || prog_corrupt || s_halt;
      led_run_err   <= in_lamp || run_err_ff;
    end
  end

  // assertions
  a_window_base: assert property (@(posedge core_clk) disable iff (!resetn)
    (dm_req && !mod_ff && dm_index > `PSS_DM_BASE_WORDS) |-> !dm_en && !dm_we_ok)
    else $error("access above base window enabled");
  a_window_ext: assert property (@(posedge core_clk) disable iff (!resetn)
    (dm_req && mod_ff && dm_index == `PSS_DM_EXT_WORDS) |-> dm_en)
    else $error("extended window word refused");
  a_lamp_on: assert property (@(posedge core_clk) disable iff (!resetn)
    in_lamp |=> (led_clock_err && led_pause && led_run_err))
    else $error("indicator dark in lamp test");
  a_clock_err: assert property (@(posedge core_clk) disable iff (!resetn)
    (clock_lost && state_ff == pss_pkg::PSS_RUN) |=> ##1 led_clock_err)
    else $error("clock error not shown");
  a_halt_pause: assert property (@(posedge core_clk) disable iff (!resetn)
    s_halt |=> (led_pause && !program_run))
    else $error("halt switch not pausing");
  a_handler_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    (err_hit && handled && !pause_ff && !run_err_ff && !pause_stmt && !host_halt)
      |=> handler_call && !run_err_ff)
    else $error("handled error raised run error");
  a_err_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    (err_hit && !handled) |=> (run_err_ff && err_cause == $past(err_k)))
    else $error("error cause not kept");
  a_index_bad: assert property (@(posedge core_clk) disable iff (!resetn)
    (sysvar_req && sysvar_index == 16'h0000) |=> err_cause == `PSS_ERR_INDEX)
    else $error("zero subscript not flagged");
endmodule

// ==== pss_far_side.sv ====
// far-side model: option clock module and host computer
`timescale 1ns/1ps
module pss_far_side (
  // clock
  input  wire logic        core_clk,
  // bench commands
  input  wire logic        fitted,
  input  wire logic        resume_req,
  input  wire logic        set_req,
  // option module lines
  output logic             module_present,
  output logic             mod_time_valid,
  output logic [15:0]      mod_year,
  output logic [7:0]       mod_month,
  output logic [7:0]       mod_day,
  output logic [7:0]       mod_hour,
  output logic [7:0]       mod_min,
  output logic [7:0]       mod_sec,
  // host command pulses
  output logic             host_resume,
  output logic             host_set_time
);
  logic [7:0] jk_ff = 8'h5A;
  logic       rq_ff = 1'h0;
  logic       sq_ff = 1'h0;
  // absent module floats its lines, so show a moving pattern
  always @(negedge core_clk)
  begin
    jk_ff <= {jk_ff[6:0], ~jk_ff[7]};
    rq_ff <= resume_req;
    sq_ff <= set_req;
  end
  // one-cycle host commands, launched off the falling edge
  assign host_resume    = resume_req & ~rq_ff;
  assign host_set_time  = set_req & ~sq_ff;
  // stored time of a fitted module; values are arbitrary
  assign module_present = fitted;
  assign mod_time_valid = fitted;
  assign mod_year       = fitted ? 16'h07E7 : {jk_ff, ~jk_ff};
  assign mod_month      = fitted ? 8'h06 : jk_ff;
  assign mod_day        = fitted ? 8'h0F : ~jk_ff;
  assign mod_hour       = fitted ? 8'h0A : jk_ff;
  assign mod_min        = fitted ? 8'h14 : ~jk_ff;
  assign mod_sec        = fitted ? 8'h1E : jk_ff;
endmodule

// ==== tb_pss_supervisor.sv ====
// self-checking bench for the status and memory supervisor
`timescale 1ns/1ps
module tb_pss_supervisor;
  localparam int LAMP = 20;
  localparam logic [15:0] DMI [6] = '{16'h0000, 16'h0001, 16'h03E8, 16'h03E9, 16'h0FA0, 16'h0FA1};
  localparam logic [15:0] SVI [4] = '{16'h0000, 16'h8001, 16'h0011, 16'h0010};
  // stimulus
  logic core_clk = 0, resetn = 0, retention_switch = 0, auth_bypass_switch = 0, fit = 0;
  logic program_halt_switch = 0, resync_disable = 0, clock_lost = 0, resume_req = 0;
  logic dm_req = 0, dm_we = 0, sysvar_req = 0, prog_corrupt = 0, pause_stmt = 0, set_req = 0;
  logic host_halt = 0, err_valid = 0, handler_reg = 0, display_fitted = 1;
  logic [15:0] dm_index = 0, sysvar_index = 0, sysvar_size = 16'h0010;
  logic [7:0] cur_min = 0, cur_sec = 8'h01, err_func = 0, handler_intr = 0;
  logic [2:0] err_kind = 0;
  // observed lines
  logic module_present, mod_time_valid, host_resume, host_set_time, dm_en, dm_we_ok, rtc_load;
  logic dm_read_zero, clear_volatile, clear_retentive, auth_bypass, program_run, disp_show;
  logic clock_lost_flag, handler_call, led_clock_err, led_pause, led_run_err;
  logic [15:0] mod_year, rtc_year;
  logic [7:0] mod_month, mod_day, mod_hour, mod_min, mod_sec, serial_fmt, err_function;
  logic [7:0] rtc_month, rtc_day, rtc_hour, rtc_min, rtc_sec, disp_function;
  logic [2:0] err_cause, disp_cause;
  logic [31:0] baud_rate;
  int fail_count = 0, samples_checked = 0;

  pss_supervisor #(.LAMP_CYC(LAMP)) u_dut (.core_clk, .resetn, .retention_switch,
    .auth_bypass_switch, .program_halt_switch, .module_present, .resync_disable, .mod_year,
    .mod_month, .mod_day, .mod_hour, .mod_min, .mod_sec, .mod_time_valid, .cur_min, .cur_sec,
    .clock_lost, .host_set_time, .dm_req, .dm_we, .dm_index, .dm_en, .dm_we_ok, .dm_read_zero,
    .sysvar_req, .sysvar_index, .sysvar_size, .prog_corrupt, .pause_stmt, .host_halt,
    .host_resume, .err_valid, .err_kind, .err_func, .handler_reg, .handler_intr,
    .display_fitted, .clear_volatile, .clear_retentive, .auth_bypass, .program_run,
    .baud_rate, .serial_fmt, .rtc_load, .rtc_year, .rtc_month, .rtc_day, .rtc_hour, .rtc_min,
    .rtc_sec, .clock_lost_flag, .handler_call, .err_cause, .err_function, .disp_show,
    .disp_cause, .disp_function, .led_clock_err, .led_pause, .led_run_err);
  pss_far_side u_far (.core_clk, .fitted(fit), .resume_req, .set_req, .module_present,
    .mod_time_valid, .mod_year, .mod_month, .mod_day, .mod_hour, .mod_min, .mod_sec,
    .host_resume, .host_set_time);

  // 50 MHz clock
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("counts: %0d checked, %0d mismatched", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // pulse picked by number: 0 clock load, 1 handler call
  function automatic logic pick(input int sel);
    return (sel == 0) ? rtc_load : handler_call;
  endfunction

  // bounded wait; a missing pulse ends the run
  task automatic wait_hi(input string nm, input int sel, input int n);
    for (int i = 0; i < n && pick(sel) !== 1'h1; i++) @(negedge core_clk);
    chk(nm, 32'h1, 32'(pick(sel)));
    if (pick(sel) !== 1'h1)
      tally_and_finish();
  endtask

  task automatic host(input logic rs);
    resume_req <= rs;
    set_req <= ~rs;
    cyc(1);
    resume_req <= 1'h0;
    set_req <= 1'h0;
    cyc(4);
  endtask

  // switches settle before release; clear pulses are gathered until the clock load
  task automatic boot(input logic r, input logic h, input logic f);
    logic cv, cr;
    resetn <= 1'h0;
    retention_switch <= r;
    program_halt_switch <= h;
    fit <= f;
    cyc(2);
    chk("lamp in reset", 32'h7, 32'({led_clock_err, led_pause, led_run_err}));
    resetn <= 1'h1;
    cv = 0;
    cr = 0;
    for (int i = 0; i < LAMP + 8 && rtc_load !== 1'h1; i++)
    begin
      @(negedge core_clk);
      if (i == LAMP - 4)
        chk("lamp", 32'h7, 32'({led_clock_err, led_pause, led_run_err}));
      cv = cv | clear_volatile;
      cr = cr | clear_retentive;
    end
    wait_hi("rtc load", 0, 1);
    chk("clears", 32'({~(r & f), ~r}), 32'({cv, cr}));
    chk("rtc date", f ? 32'h07E7_060F : 32'h07D0_0101,
        {rtc_year, rtc_month, rtc_day});
    chk("rtc time", f ? 32'h000A_141E : 32'h0,
        {8'h00, rtc_hour, rtc_min, rtc_sec});
    cyc(3);
    chk("leds", 32'({1'h0, h, 1'h0}),
        32'({led_clock_err, led_pause, led_run_err}));
    chk("baud", h ? 32'h0000_9600 : 32'h0, baud_rate);
    chk("run and format", 32'({~h, 8'h00}), 32'({program_run, serial_fmt}));
  endtask

  task automatic dm_sweep(input logic [15:0] lim);
    logic en;
    for (int k = 0; k < 12; k++)
    begin
      dm_req <= 1'h1;
      dm_we <= k[0];
      dm_index <= DMI[k / 2];
      cyc(1);
      en = DMI[k / 2] != 0 && DMI[k / 2] <= lim;
      chk("dm", 32'({en, en & k[0], ~en & ~k[0]}),
          32'({dm_en, dm_we_ok, dm_read_zero}));
    end
    dm_req <= 1'h0;
  endtask

  task automatic fault(input logic [2:0] kind, input logic [15:0] idx, input logic sv);
    err_valid <= ~sv;
    err_kind <= kind;
    err_func <= 8'h40 + 8'(kind);
    sysvar_req <= sv;
    sysvar_index <= idx;
    cyc(1);
    err_valid <= 1'h0;
    sysvar_req <= 1'h0;
  endtask

  initial
  begin
    logic e;
    boot(1'h0, 1'h0, 1'h0);
    dm_sweep(16'h03E8);
    $display("test base boot done");
    // only kinds 1 to 5 are reported
    for (int k = 0; k < 8; k++)
    begin
      fault(3'(k), 16'h0001, 1'h0);
      cyc(3);
      e = k >= 1 && k <= 5;
      chk("error leds", 32'({e, e, ~e}),
          32'({led_pause, led_run_err, program_run}));
      if (e)
        chk("report", 32'({3'(k), 8'h40 + 8'(k), 1'h1}),
            32'({err_cause, err_function, disp_show}));
      if (e)
        chk("display", 32'({3'(k), 8'h40 + 8'(k)}), 32'({disp_cause, disp_function}));
      host(1'h1);
      chk("resumed", 32'h0, 32'({led_pause, led_run_err}));
    end
    // no display fitted here: the report must not claim the screen
    display_fitted <= 1'h0;
    for (int k = 0; k < 4; k++)
    begin
      fault(3'h0, SVI[k], 1'h1);
      cyc(3);
      chk("index error", 32'({k != 3, 3'h5, 1'h0}),
          32'({led_run_err, err_cause, disp_show}));
      host(1'h1);
    end
    display_fitted <= 1'h1;
    $display("test errors done");
    handler_reg <= 1'h1;
    handler_intr <= 8'h64;
    fault(3'h1, 16'h0001, 1'h0);
    wait_hi("handler call", 1, 4);
    cyc(2);
    chk("handled", 32'h3, 32'({led_pause, led_run_err, disp_show, program_run}));
    handler_reg <= 1'h0;
    for (int k = 0; k < 3; k++)
    begin
      {prog_corrupt, pause_stmt, host_halt} <= 3'(1 << k);
      cyc(1);
      pause_stmt <= 1'h0;
      host_halt <= 1'h0;
      cyc(3);
      chk("pause lit", 32'h2, 32'({led_pause, program_run}));
      host(1'h1);
      chk("pause resumed", 32'(k == 2), 32'(led_pause));
      prog_corrupt <= 1'h0;
      cyc(4);
    end
    $display("test handler and pause done");
    clock_lost <= 1'h1;
    auth_bypass_switch <= 1'h1;
    cyc(1);
    clock_lost <= 1'h0;
    cyc(3);
    chk("clock lost", 32'h7, 32'({led_clock_err, clock_lost_flag, auth_bypass}));
    host(1'h0);
    chk("clock set", 32'h0, 32'({led_clock_err, clock_lost_flag}));
    $display("test clock and bypass done");
    boot(1'h1, 1'h1, 1'h1);
    dm_sweep(16'h0FA0);
    host(1'h1);
    chk("switch pause held", 32'h1, 32'(led_pause));
    cur_sec <= 8'h00;
    wait_hi("hourly resync", 0, 4);
    cur_sec <= 8'h01;
    resync_disable <= 1'h1;
    cyc(4);
    cur_sec <= 8'h00;
    e = 0;
    repeat (5)
    begin
      @(negedge core_clk);
      e = e | rtc_load;
    end
    chk("resync off", 32'h0, 32'(e));
    $display("test module boot done");
    tally_and_finish();
  end
endmodule
